// ===== design/dac_loader_map.svh
// Constants for the serial DAC word loader: word layout, reset values, timing.
// Assumes inclusion by design files only; definitions, no logic.
`ifndef DAC_LOADER_MAP_SVH
`define DAC_LOADER_MAP_SVH

// -----------------------------------------------------------------
// Serial word layout
// -----------------------------------------------------------------
`define WORD_BITS        16
`define CODE_BITS        12
`define CTRL_HIGH_POS    15
`define CTRL_MID_POS     14
`define CTRL_LOW_POS     13
`define CODE_MSB_POS     12
`define CODE_LSB_POS     1
`define SUB_BIT_POS      0

// -----------------------------------------------------------------
// Reset values and timing
// -----------------------------------------------------------------
`define CODE_RESET       12'h000
`define WORD_RESET       16'h0000
`define SYS_CLK_NS       20
`define SETTLE_TIME_US   20
`define SETTLE_CYCLES    ((`SETTLE_TIME_US * 1000 + `SYS_CLK_NS - 1) / `SYS_CLK_NS)

`endif

// ===== design/dac_loader_pkg.sv
// Types for the serial DAC word loader.
// Assumes the map header supplies widths.
`include "dac_loader_map.svh"

package dac_loader_pkg;

   typedef logic [`CODE_BITS-1:0] code_t;
   typedef logic [`WORD_BITS-1:0] word_t;

   // Command decoded from the two low control bits (top bit picks shutdown)
   typedef enum logic [1:0] {
      cmd_load_update,
      cmd_load_only,
      cmd_update,
      cmd_high_pair
   } cmd_t;

endpackage : dac_loader_pkg

// ===== design/pin_sync.sv
// Two-flop synchroniser for one pin.
// Assumes an asynchronous pin and a free-running sampling clock.
module pin_sync #(
   parameter logic RESET_VALUE = 1'b0
) (
   input  wire logic i_clk_sys,   // Sampling clock
   input  wire logic i_reset,     // Async reset, active high
   input  wire logic i_pin,       // Asynchronous pin
   output logic      o_sync       // Synchronised level
);

   logic [1:0] stage;

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         stage <= {RESET_VALUE, RESET_VALUE};
      end else begin
         stage <= {stage[0], i_pin};
      end
   end

   assign o_sync = stage[1];

endmodule : pin_sync

// ===== design/serial_dac_word_loader.sv
// Serial write-only front end of a 12-bit DAC: shift register, input and DAC registers.
// Assumes the host drives chip select, serial clock and data asynchronously to i_clk_sys,
// with the serial clock at least five system clocks per period.
//
// Operation
// [RQ1] A transfer carries sixteen serial bits into a sixteen-bit shift register.
// [RQ2] Word is MSB first: three control bits, twelve code bits, one sub-bit.
// [RQ3] Host always sends the sub-bit as zero.
// [RQ4] Low control 00: load input, copy to DAC, leave shutdown.
// [RQ5] Low control 01: load input register only.
// [RQ6] Low control 10: copy input to DAC, ignore data, leave shutdown.
// [RQ7] Control 111 enters shutdown regardless of the other thirteen bits.
// [RQ8] Update, shutdown and 011 ignore data; 011 changes nothing.
// [RQ9] In shutdown, amplifier output and reference input are high impedance.
// [RQ10] Receiver keeps decoding words during shutdown.
// [RQ11] Shutdown leaves the input register untouched.
// [RQ12] Host waits 20 us after power-up or shutdown exit.
// [RQ13] Chip select high disables the interface; clock and data ignored.
// [RQ14] Chip select low: data sampled on each serial clock rising edge.
// [RQ15] Chip select rising edge decodes and applies the word.
// [RQ16] Chip select stays low for all sixteen bits, any packet split.
// [RQ17] Host keeps serial clock at or below 10 MHz.
// [RQ18] Reset clears input and DAC registers to zero.
// [RQ19] Code is straight binary 0 to 4095, output code over 4096.
// [RQ20] Several converters need separate chip selects.
// [RQ21] Odd bit counts decode the sixteen most recent bits.
`include "dac_loader_map.svh"

module serial_dac_word_loader (
   input  wire logic                  i_clk_sys,      // System clock, 50 MHz
   input  wire logic                  i_reset,        // Async reset (power-up), active high
   input  wire logic                  i_cs_n,         // Chip select pin, active low
   input  wire logic                  i_sclk,         // Serial clock pin
   input  wire logic                  i_din,          // Serial data pin
   output dac_loader_pkg::code_t      o_input_code,   // Input register
   output dac_loader_pkg::code_t      o_dac_code,     // DAC register, numeric_code_value
   output logic                       o_shutdown,     // Shutdown mode active
   output logic                       o_amp_out_en,   // Amplifier output drive enable
   output logic                       o_ref_in_en,    // Reference input connect enable
   output logic                       o_settled,      // Settling time has elapsed
   output logic                       o_word_done     // One-cycle pulse per applied word
);

   import dac_loader_pkg::*;

   localparam int SETTLE_CYC = `SETTLE_CYCLES;
   localparam int SETTLE_W   = $clog2(SETTLE_CYC + 1);

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic cs_n_s;
   logic sclk_s;
   logic din_s;

   // Chip select resets to deselected so no false decode follows reset
   pin_sync #(.RESET_VALUE(1'b1)) u_sync_cs (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_pin     (i_cs_n),
      .o_sync    (cs_n_s)
   );

   pin_sync #(.RESET_VALUE(1'b0)) u_sync_sclk (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_pin     (i_sclk),
      .o_sync    (sclk_s)
   );

   pin_sync #(.RESET_VALUE(1'b0)) u_sync_din (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_pin     (i_din),
      .o_sync    (din_s)
   );

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic                cs_n_d;
      logic                sclk_d;
      word_t               shift;
      code_t               input_code;
      code_t               dac_code;
      logic                shutdown;
      logic [SETTLE_W-1:0] settle;
      logic                done;
   } state_t;

   state_t st;
   state_t next_st;

   logic sclk_rise;
   logic cs_rise;
   logic ctrl_high;
   cmd_t cmd;
   code_t word_code;

   // Edge flops start at the idle pin levels, so reset release shows no edge
   assign sclk_rise = sclk_s & ~st.sclk_d;
   assign cs_rise   = cs_n_s & ~st.cs_n_d;
   // Top control bit only separates shutdown from no-op in the 11 pair
   assign ctrl_high = st.shift[`CTRL_HIGH_POS];
   assign cmd       = cmd_t'({st.shift[`CTRL_MID_POS], st.shift[`CTRL_LOW_POS]});
   assign word_code = st.shift[`CODE_MSB_POS:`CODE_LSB_POS];

   always_comb begin
      next_st        = st;
      next_st.cs_n_d = cs_n_s;
      next_st.sclk_d = sclk_s;
      next_st.done   = 1'b0;
      if (st.settle != '0) begin
         next_st.settle = st.settle - 1'b1;
      end
      // Shift only while selected; deselected edges fall through
      if (!cs_n_s && sclk_rise) begin  // RQ13
         next_st.shift = {st.shift[`WORD_BITS-2:0], din_s};  // RQ14 RQ1 RQ21
      end
      // Decode on deselect, also during shutdown
      if (cs_rise) begin  // RQ15 RQ10
         next_st.done = 1'b1;
         unique case (cmd)  // RQ2
            cmd_load_update: begin  // RQ4
               next_st.input_code = word_code;
               next_st.dac_code   = word_code;
               if (st.shutdown) begin
                  next_st.settle = SETTLE_W'(SETTLE_CYC);
               end
               next_st.shutdown = 1'b0;
            end
            cmd_load_only: begin  // RQ5
               next_st.input_code = word_code;
            end
            cmd_update: begin  // RQ6 RQ8
               next_st.dac_code = st.input_code;
               if (st.shutdown) begin
                  next_st.settle = SETTLE_W'(SETTLE_CYC);
               end
               next_st.shutdown = 1'b0;
            end
            cmd_high_pair: begin  // RQ8
               if (ctrl_high) begin
                  next_st.shutdown = 1'b1;  // RQ7 RQ11
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         st.cs_n_d     <= 1'b1;
         st.sclk_d     <= 1'b0;
         st.shift      <= `WORD_RESET;
         st.input_code <= `CODE_RESET;  // RQ18
         st.dac_code   <= `CODE_RESET;  // RQ18
         st.shutdown   <= 1'b0;
         // Count starts full so the settled flag also covers power-up
         st.settle     <= SETTLE_W'(SETTLE_CYC);
         st.done       <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign o_input_code = st.input_code;
   assign o_dac_code   = st.dac_code;  // RQ19
   assign o_shutdown   = st.shutdown;
   // Enables stand in for the analog switches; low means high impedance
   assign o_amp_out_en = ~st.shutdown;  // RQ9
   assign o_ref_in_en  = ~st.shutdown;  // RQ9
   assign o_settled    = (st.settle == '0);
   assign o_word_done  = st.done;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_reset);

   // Power-up values, checked while reset is still held
   reset_clear_a: assert property (disable iff (1'b0)  // RQ18
      i_reset
      |=> o_input_code == '0 && o_dac_code == '0 && !o_shutdown && !o_settled
   ) else $error("Registers not cleared by reset");

   // ---------------------------------------------------------------
   // Receiver
   // ---------------------------------------------------------------
   // Bits enter only while selected and only on a serial clock rise
   idle_no_shift_a: assert property (  // RQ13
      cs_n_s
      |=> $stable(st.shift)
   ) else $error("Shift register moved while deselected");
   rise_only_a: assert property (  // RQ14
      !sclk_rise
      |=> $stable(st.shift)
   ) else $error("Shift register moved without a clock rise");
   shift_sample_a: assert property (  // RQ14
      !cs_n_s && sclk_rise
      |=> st.shift[0] == $past(din_s)
   ) else $error("Data bit not sampled");
   shift_order_a: assert property (  // RQ21
      !cs_n_s && sclk_rise
      |=> st.shift[`WORD_BITS-1:1] == $past(st.shift[`WORD_BITS-2:0])
   ) else $error("Earlier bits not moved up");

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   // Every effect lands one cycle after the synchronised deselect
   load_update_a: assert property (  // RQ4
      cs_rise && cmd == cmd_load_update
      |=> o_dac_code == $past(word_code) && o_input_code == $past(word_code) && !o_shutdown
   ) else $error("Load and update failed");
   load_only_a: assert property (  // RQ5
      cs_rise && cmd == cmd_load_only
      |=> $stable(o_dac_code) && $stable(o_shutdown) && o_input_code == $past(word_code)
   ) else $error("Load only touched DAC register");
   update_a: assert property (  // RQ6
      cs_rise && cmd == cmd_update
      |=> o_dac_code == $past(o_input_code) && !o_shutdown && $stable(o_input_code)
   ) else $error("Update from input failed");
   shutdown_enter_a: assert property (  // RQ7
      cs_rise && cmd == cmd_high_pair && ctrl_high
      |=> o_shutdown && $stable(o_input_code) && $stable(o_dac_code)
   ) else $error("Shutdown entry wrong");
   shutdown_source_a: assert property (  // RQ7
      $rose(o_shutdown)
      |-> $past(cs_rise) && $past(cmd) == cmd_high_pair && $past(ctrl_high)
   ) else $error("Shutdown entered without its command");
   nop_keep_a: assert property (  // RQ8
      cs_rise && cmd == cmd_high_pair && !ctrl_high
      |=> $stable(o_shutdown) && $stable(o_input_code) && $stable(o_dac_code)
   ) else $error("No-operation changed state");
   no_decode_idle_a: assert property (  // RQ15
      !cs_rise
      |=> !o_word_done
   ) else $error("Word applied without deselect");
   decode_pulse_a: assert property (  // RQ15
      cs_rise
      |=> o_word_done
   ) else $error("Deselect did not apply a word");
   single_pulse_a: assert property (  // RQ15
      o_word_done
      |=> !o_word_done
   ) else $error("Completion pulse longer than one cycle");
   regs_hold_a: assert property (  // RQ15
      !cs_rise
      |=> $stable(o_input_code) && $stable(o_dac_code) && $stable(o_shutdown)
   ) else $error("Registers changed between words");

   // ---------------------------------------------------------------
   // Shutdown and settling
   // ---------------------------------------------------------------
   // Enables, retention of the input register and the settle counter
   hiz_shutdown_a: assert property (  // RQ9
      o_shutdown
      |-> !o_amp_out_en && !o_ref_in_en
   ) else $error("Outputs driven in shutdown");
   drive_active_a: assert property (  // RQ9
      !o_shutdown
      |-> o_amp_out_en && o_ref_in_en
   ) else $error("Outputs released while active");
   decode_in_sd_a: assert property (  // RQ10
      o_shutdown && cs_rise && cmd == cmd_load_only
      |=> o_shutdown && o_input_code == $past(word_code)
   ) else $error("Word lost during shutdown");
   recall_level_a: assert property (  // RQ11
      o_shutdown && cs_rise && cmd == cmd_update
      |=> o_dac_code == $past(o_input_code) && !o_shutdown
   ) else $error("Held level not recalled on exit");
   settle_exit_a: assert property (  // RQ12
      o_shutdown ##1 !o_shutdown
      |-> !o_settled
   ) else $error("Settle flag not restarted on exit");
   settle_reload_a: assert property (  // RQ12
      o_shutdown && cs_rise && (cmd == cmd_load_update || cmd == cmd_update)
      |=> !o_settled && st.settle == SETTLE_W'(SETTLE_CYC)
   ) else $error("Settle counter not reloaded on exit");
   settle_count_a: assert property (  // RQ12
      !o_settled && !cs_rise
      |=> st.settle == $past(st.settle) - SETTLE_W'(1)
   ) else $error("Settle counter stalled");
   settled_hold_a: assert property (  // RQ12
      o_settled && !cs_rise
      |=> o_settled
   ) else $error("Settle flag dropped without a word");

   // ---------------------------------------------------------------
   // Scenario covers
   // ---------------------------------------------------------------
   cv_load_update_c: cover property (cs_rise && cmd == cmd_load_update);
   cv_shutdown_c:    cover property (cs_rise && cmd == cmd_high_pair && ctrl_high);
   cv_nop_c:         cover property (cs_rise && cmd == cmd_high_pair && !ctrl_high);
   cv_recall_c:      cover property (o_shutdown ##1 !o_shutdown);
   cv_load_in_sd_c:  cover property (o_shutdown && cs_rise && cmd == cmd_load_only);

endmodule : serial_dac_word_loader

// ===== test/serial_dac_word_loader_tb.sv
// Self-checking bench for the serial DAC word loader.
// Assumes the host model and the design files are compiled first.
module serial_dac_word_loader_tb import dac_loader_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic  clk = 1'b0;
   logic  reset = 1'b1;
   logic  cs_n, sclk, din, shutdown, amp_en, ref_en, settled, word_done, exp_sd;
   code_t input_code, dac_code, exp_in, exp_dac;
   int    mismatches = 0;
   int    comparisons = 0;
   always #10 clk = ~clk;
   serial_host_model i_host (.i_clk_sys(clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));
   serial_dac_word_loader i_dut (
      .i_clk_sys(clk), .i_reset(reset), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din),
      .o_input_code(input_code), .o_dac_code(dac_code), .o_shutdown(shutdown),
      .o_amp_out_en(amp_en), .o_ref_in_en(ref_en), .o_settled(settled),
      .o_word_done(word_done));
   // ----
   // Checking and reporting
   // ----
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up
   task automatic check(input logic [11:0] seen, input logic [11:0] want, input string what);
      comparisons++;
      if (seen !== want) begin
         mismatches++;
         $display("MISMATCH %0t %s: seen %h want %h", $time, what, seen, want);
      end
   endtask : check
   task automatic expect_regs(input code_t in, input code_t dac, input logic sd);
      exp_in = in;
      exp_dac = dac;
      exp_sd = sd;
   endtask : expect_regs
   task automatic check_state(input string what);
      check(input_code, exp_in, what);
      check(dac_code, exp_dac, what);
      check(12'(shutdown), 12'(exp_sd), what);
      check(12'(amp_en), 12'(!exp_sd), what);
      check(12'(ref_en), 12'(!exp_sd), what);
   endtask : check_state
   // One frame, then the applied state once the completion pulse shows
   task automatic xfer(input logic [15:0] word, input int junk, input string what);
      int n;
      i_host.send(word, junk);
      n = 0;
      while (word_done !== 1'b1) begin
         @(negedge clk);
         n++;
         if (n > 20) begin
            mismatches++;
            $display("MISMATCH %0t %s: no completion", $time, what);
            wrap_up();
         end
      end
      check_state(what);
   endtask : xfer
   // ----
   // Scenarios
   // ----
   task automatic t_loads();
      expect_regs(12'h000, 12'h000, 1'b0);
      @(negedge clk);
      check_state("reset");
      check(12'(settled), 12'h000, "settle after reset");
      expect_regs(12'hA5C, 12'hA5C, 1'b0);
      xfer({3'b100, 12'hA5C, 1'b0}, 0, "load update");
      expect_regs(12'hFFF, 12'hA5C, 1'b0);
      xfer({3'b001, 12'hFFF, 1'b0}, 0, "load only");
      expect_regs(12'h800, 12'h800, 1'b0);
      xfer({3'b000, 12'h800, 1'b0}, 4, "long frame");
      expect_regs(12'h800, 12'h800, 1'b0);
      xfer({3'b011, 12'h5A5, 1'b0}, 0, "no operation");
      $display("Test loads done");
   endtask : t_loads
   task automatic t_shutdown();
      expect_regs(12'h800, 12'h800, 1'b1);
      xfer({3'b111, 12'h123, 1'b0}, 0, "shutdown");
      expect_regs(12'h3C3, 12'h800, 1'b1);
      xfer({3'b101, 12'h3C3, 1'b0}, 0, "load in shutdown");
      expect_regs(12'h3C3, 12'h3C3, 1'b0);
      xfer({3'b010, 12'h555, 1'b0}, 0, "update");
      repeat (985) @(negedge clk);
      check(12'(settled), 12'h000, "settle early");
      repeat (30) @(negedge clk);
      check(12'(settled), 12'h001, "settle late");
      expect_regs(12'h3C3, 12'h3C3, 1'b1);
      xfer({3'b111, 12'h000, 1'b0}, 0, "shutdown again");
      expect_regs(12'h001, 12'h001, 1'b0);
      xfer({3'b000, 12'h001, 1'b0}, 0, "exit by load");
      $display("Test shutdown done");
   endtask : t_shutdown
   task automatic t_deselected();
      i_host.noise();
      for (int i = 0; i < 40; i++) begin
         @(negedge clk);
         check(12'(word_done), 12'h000, "deselected pulse");
      end
      check_state("deselected");
      expect_regs(12'h17F, 12'h17F, 1'b0);
      xfer(16'h00FE, -8, "short after noise");
      $display("Test deselected done");
   endtask : t_deselected
   initial begin
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      t_loads();
      t_shutdown();
      t_deselected();
      wrap_up();
   end
endmodule : serial_dac_word_loader_tb

// ===== test/serial_host_model.sv
// Host model: drives chip select, serial clock and data of the converter.
// Assumes the bench calls its tasks; pins move just after i_clk_sys rises.
module serial_host_model (
   input  wire logic i_clk_sys, // Bench clock, 20 ns
   output logic      o_cs_n,    // Chip select, active low
   output logic      o_sclk,    // Serial clock, low between frames except while noise runs
   output logic      o_din      // Serial data
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b0;
      o_din  = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask : tick
   // ----
   // Frame: junk leading ones (negative: low bits only), then the word; 160 ns per bit
   // ----
   task automatic send(input logic [15:0] word, input int junk);
      logic [19:0] bits;
      bits = {4'hF, word};
      tick(1);
      o_cs_n <= 1'b0;
      for (int i = junk + 15; i >= 0; i--) begin
         tick(4);
         o_sclk <= 1'b0;
         o_din  <= bits[i];
         tick(4);
         o_sclk <= 1'b1;
      end
      tick(4);
      o_sclk <= 1'b0;
      o_din  <= ~o_din;
      tick(4);
      o_cs_n <= 1'b1;
   endtask : send
   // Clock and data activity while deselected
   task automatic noise();
      for (int i = 0; i < 16; i++) begin
         tick(4);
         o_sclk <= ~o_sclk;
         o_din  <= ~o_din;
      end
   endtask : noise
endmodule : serial_host_model
